// ==== logic/mcs_pkg.sv ====
// Constants, field values and mode codes shared by the mode-change sequencer.
// Assumes one 125 MHz system clock; all phase timing counts one-second ticks.
package mcs_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int unsigned CLK_HZ         = 125_000_000;
  localparam int unsigned TICK_PERIOD_S  = 1;
  localparam int unsigned SEC_CYCLES     = CLK_HZ * TICK_PERIOD_S;
  localparam int unsigned CAL_PHASE_S    = 30;
  localparam int unsigned CYCLE_MIN      = 33;
  localparam int unsigned CYCLE_EXTRA_S  = 50;
  localparam int unsigned CYCLE_S        = CYCLE_MIN * 60 + CYCLE_EXTRA_S;
  localparam int unsigned LO_SWITCH_S    = 5;
  localparam int unsigned CONT_SET_S     = 5;
  localparam int unsigned TIMER_W        = 12;

  // ==========================================================================
  // Packet layout, one byte per index
  localparam logic [3:0] PKT_BYTES       = 4'he;
  localparam logic [3:0] IDX_ID_HI       = 4'h0;
  localparam logic [3:0] IDX_ID_LO       = 4'h1;
  localparam logic [3:0] IDX_SEQ_HI      = 4'h2;
  localparam logic [3:0] IDX_SEQ_LO      = 4'h3;
  localparam logic [3:0] IDX_LEN_HI      = 4'h4;
  localparam logic [3:0] IDX_LEN_LO      = 4'h5;
  localparam logic [3:0] IDX_SEC_HDR     = 4'h6;
  localparam logic [3:0] IDX_TYPE        = 4'h7;
  localparam logic [3:0] IDX_SUBTYPE     = 4'h8;
  localparam logic [3:0] IDX_PAD         = 4'h9;
  localparam logic [3:0] IDX_DATA_HI     = 4'ha;
  localparam logic [3:0] IDX_DATA_LO     = 4'hb;
  localparam logic [3:0] IDX_LAST        = 4'hd;

  // Fixed header fields
  localparam logic [2:0]  HDR_VERSION    = 3'h0;
  localparam logic        HDR_TYPE       = 1'b1;
  localparam logic        HDR_SEC_FLAG   = 1'b1;
  localparam logic [6:0]  HDR_APID       = 7'h47;
  localparam logic [3:0]  HDR_CATEGORY   = 4'hc;
  localparam logic [1:0]  HDR_SEQ_FLAGS  = 2'h3;
  localparam logic [2:0]  HDR_SRC_GROUND = 3'h0;
  localparam logic [15:0] HDR_LENGTH     = 16'h0007;
  localparam logic [2:0]  SVC_VERSION    = 3'h0;
  localparam logic        SVC_CKSUM_FLAG = 1'b1;
  localparam logic [3:0]  SVC_ACK        = 4'h1;
  localparam logic [7:0]  SVC_TYPE       = 8'hc0;
  localparam logic [7:0]  SVC_SUBTYPE    = 8'h05;
  localparam logic [7:0]  SVC_PAD        = 8'h00;

  // Application data word fields
  localparam int unsigned AD_MODE_MSB    = 15;
  localparam int unsigned AD_INTEG_MSB   = 12;
  localparam int unsigned AD_SUM_MSB     = 10;
  localparam int unsigned AD_SMOOTH_MSB  = 7;

  // ==========================================================================
  // Power mode codes
  localparam logic [2:0] MODE_SPEC_DUAL  = 3'h1;
  localparam logic [2:0] MODE_SPEC_SMM   = 3'h2;
  localparam logic [2:0] MODE_DUAL       = 3'h3;
  localparam logic [2:0] MODE_SMM        = 3'h4;
  localparam logic [2:0] MODE_MM         = 3'h5;
  localparam logic [2:0] MODE_ENG        = 3'h6;

  // Data-volume defaults
  localparam logic [1:0] INTEG_RESET     = 2'h0;
  localparam logic [2:0] SUM_RESET       = 3'h0;
  localparam logic [1:0] SMOOTH_RESET    = 2'h0;
  localparam logic [2:0] SUM_CODE_MAX    = 3'h4;

  // Observation sequence states
  typedef enum logic [4:0] {
    MCS_SEQ_IDLE = 5'b00001,
    MCS_SEQ_HOT  = 5'b00010,
    MCS_SEQ_COLD = 5'b00100,
    MCS_SEQ_CAL  = 5'b01000,
    MCS_SEQ_SRC  = 5'b10000
  } mcs_seq_t;

endpackage

// ==== logic/mcs_tick_gen.sv ====
// One-second tick divider for the mode-change sequencer.
// Assumes clk_sys is free running; tick is a one-cycle enable pulse.
`timescale 1ns/100ps
module mcs_tick_gen #(
  parameter int unsigned CYCLES = mcs_pkg::SEC_CYCLES
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // Enable out
  output logic      tick
);
  import mcs_pkg::*;

  localparam logic [31:0] LAST = 32'(CYCLES - 1);

  logic [31:0] count;

  // ==========================================================================
  // Divider
  // Free running so every timer shares one phase of the second
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count <= 32'h0;
      tick  <= 1'b0;
    end else if (count == LAST) begin
      count <= 32'h0;
      tick  <= 1'b1;
    end else begin
      count <= count + 32'h1;
      tick  <= 1'b0;
    end
  end

endmodule

// ==== logic/mcs_period_counter.sv ====
// Restartable counter of one-second ticks with a wrap pulse.
// Assumes tick is a one-cycle enable from the shared divider.
`timescale 1ns/100ps
module mcs_period_counter #(
  parameter int unsigned W = mcs_pkg::TIMER_W
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  // Control
  input  wire logic         restart,
  input  wire logic         tick,
  input  wire logic [W-1:0] length,
  // Status
  output logic              wrap,
  output logic [W-1:0]      count
);
  import mcs_pkg::*;

  // ==========================================================================
  // Counter
  // Restart wins over a coincident tick so a new sequence starts clean
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
      wrap  <= 1'b0;
    end else if (restart) begin
      count <= '0;
      wrap  <= 1'b0;
    end else if (tick && (count == length - W'(1))) begin
      count <= '0;
      wrap  <= 1'b1;
    end else if (tick) begin
      count <= count + W'(1);
      wrap  <= 1'b0;
    end else begin
      wrap  <= 1'b0;
    end
  end

endmodule

// ==== logic/mcs_sequencer.sv ====
// Mode-change telecommand checker, mode controller and observation sequencer.
// Assumes telecommand bytes arrive synchronous to clk_sys, first byte flagged.
`timescale 1ns/100ps

module mcs_sequencer #(
  parameter int unsigned SEC_CYCLES = mcs_pkg::SEC_CYCLES
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  // Telecommand byte stream
  input  wire logic       tc_valid,
  input  wire logic       tc_first,
  input  wire logic [7:0] tc_byte,
  // Subsystem status
  input  wire logic       osc_ready,
  input  wire logic       lo_locked,
  input  wire logic       ifp_ready,
  // Command result
  output logic            cmd_accept,
  output logic            cmd_reject,
  output logic [10:0]     last_tc_count,
  // Mode and data-volume settings
  output logic [2:0]      power_mode,
  output logic [1:0]      integ_code,
  output logic [2:0]      sum_code,
  output logic [1:0]      smooth_code,
  // Power enables
  output logic            flight_computer_en,
  output logic            mm_rx_en,
  output logic            smm_rx_en,
  output logic            stable_reference_oscillator_en,
  output logic            spectro_en,
  // Data products
  output logic            eng_tm_en,
  output logic            cont_data_en,
  output logic            spec_data_en,
  output mcs_pkg::mcs_seq_t seq_state,
  output logic            plus_offset_setting,
  output logic            minus_offset_setting,
  output logic            spec_cal_dump,
  output logic            spec_sig_dump,
  output logic            spec_sig_diff,
  output logic [2:0]      spec_avg_sets,
  output logic            cont_dump,
  output logic [4:0]      cont_sum_sets
);
  import mcs_pkg::*;

  // ==========================================================================
  // Packet reception state
  logic [3:0]  byte_idx;
  logic        pkt_ok;
  logic        pkt_active;
  logic [15:0] app_data;
  logic [10:0] rx_count;
  logic        byte_ok;
  logic        pkt_done;
  logic [2:0]  rx_mode;
  logic        mode_ok;

  // Expected value of each fixed byte
  always_comb begin
    byte_ok = 1'b1;
    case (byte_idx)
      IDX_ID_HI:   byte_ok = (tc_byte == {HDR_VERSION, HDR_TYPE, HDR_SEC_FLAG, HDR_APID[6:4]});
      IDX_ID_LO:   byte_ok = (tc_byte == {HDR_APID[3:0], HDR_CATEGORY});
      IDX_SEQ_HI:  byte_ok = (tc_byte[7:3] == {HDR_SEQ_FLAGS, HDR_SRC_GROUND});
      IDX_LEN_HI:  byte_ok = (tc_byte == HDR_LENGTH[15:8]);
      IDX_LEN_LO:  byte_ok = (tc_byte == HDR_LENGTH[7:0]);
      IDX_SEC_HDR: byte_ok = (tc_byte == {SVC_VERSION, SVC_CKSUM_FLAG, SVC_ACK});
      IDX_TYPE:    byte_ok = (tc_byte == SVC_TYPE);
      IDX_SUBTYPE: byte_ok = (tc_byte == SVC_SUBTYPE);
      IDX_PAD:     byte_ok = (tc_byte == SVC_PAD);
      default:     byte_ok = 1'b1;
    endcase
  end

  // Index of the byte being offered; a first byte always counts as index 0
  logic [3:0] cur_idx;
  assign cur_idx  = tc_first ? IDX_ID_HI : byte_idx;
  assign pkt_done = tc_valid && (pkt_active || tc_first) && (cur_idx == IDX_LAST);

  // ==========================================================================
  // Byte walker
  // Checksum bytes are counted but not verified here
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      byte_idx   <= 4'h0;
      pkt_active <= 1'b0;
    end else if (tc_valid && tc_first) begin
      byte_idx   <= IDX_ID_LO;
      pkt_active <= 1'b1;
    end else if (tc_valid && pkt_active) begin
      byte_idx   <= (byte_idx == IDX_LAST) ? 4'h0 : byte_idx + 4'h1;
      pkt_active <= (byte_idx != IDX_LAST);
    end
  end

  // Running verdict over the fixed fields
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pkt_ok <= 1'b0;
    end else if (tc_valid && tc_first) begin
      pkt_ok <= (tc_byte == {HDR_VERSION, HDR_TYPE, HDR_SEC_FLAG, HDR_APID[6:4]});
    end else if (tc_valid && pkt_active) begin
      pkt_ok <= pkt_ok && byte_ok;
    end
  end

  // Captured sequence count and application data
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rx_count <= 11'h000;
      app_data <= 16'h0000;
    end else if (tc_valid && pkt_active) begin
      if (byte_idx == IDX_SEQ_HI) begin
        rx_count[10:8] <= tc_byte[2:0];
      end
      if (byte_idx == IDX_SEQ_LO) begin
        rx_count[7:0] <= tc_byte;
      end
      if (byte_idx == IDX_DATA_HI) begin
        app_data[15:8] <= tc_byte;
      end
      if (byte_idx == IDX_DATA_LO) begin
        app_data[7:0] <= tc_byte;
      end
    end
  end

  // Only the six defined codes are taken; others reject the whole command
  assign rx_mode = app_data[AD_MODE_MSB -: 3];
  assign mode_ok = (rx_mode >= MODE_SPEC_DUAL) && (rx_mode <= MODE_ENG);

  logic apply_cmd;
  assign apply_cmd = pkt_done && pkt_ok && mode_ok &&
                     (app_data[AD_SUM_MSB -: 3] <= SUM_CODE_MAX);

  // ==========================================================================
  // Command result pulses
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cmd_accept    <= 1'b0;
      cmd_reject    <= 1'b0;
      last_tc_count <= 11'h000;
    end else begin
      cmd_accept <= apply_cmd;
      cmd_reject <= pkt_done && !apply_cmd;
      if (apply_cmd) begin
        last_tc_count <= rx_count;
      end
    end
  end

  // ==========================================================================
  // Mode and data-volume settings
  // A rejected packet leaves every setting as it was
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      power_mode  <= MODE_ENG;
      integ_code  <= INTEG_RESET;
      sum_code    <= SUM_RESET;
      smooth_code <= SMOOTH_RESET;
    end else if (apply_cmd) begin
      power_mode  <= rx_mode;
      integ_code  <= app_data[AD_INTEG_MSB -: 2];
      sum_code    <= app_data[AD_SUM_MSB -: 3];
      smooth_code <= app_data[AD_SMOOTH_MSB -: 2];
    end
  end

  // Mode class decode
  logic is_spec;
  logic want_mm;
  logic want_smm;
  assign is_spec  = (power_mode == MODE_SPEC_DUAL) || (power_mode == MODE_SPEC_SMM);
  assign want_mm  = (power_mode == MODE_MM) || (power_mode == MODE_DUAL) || (power_mode == MODE_SPEC_DUAL);
  assign want_smm = (power_mode == MODE_SMM) || (power_mode == MODE_DUAL) || is_spec;

  // ==========================================================================
  // Power enables and data products
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      flight_computer_en             <= 1'b1;
      mm_rx_en                       <= 1'b0;
      smm_rx_en                      <= 1'b0;
      stable_reference_oscillator_en <= 1'b0;
      spectro_en                     <= 1'b0;
      eng_tm_en                      <= 1'b1;
      cont_data_en                   <= 1'b0;
      spec_data_en                   <= 1'b0;
    end else begin
      flight_computer_en             <= 1'b1;
      eng_tm_en                      <= (power_mode == MODE_ENG);
      mm_rx_en                       <= want_mm;
      smm_rx_en                      <= want_smm;
      stable_reference_oscillator_en <= is_spec;
      spectro_en                     <= is_spec;
      cont_data_en                   <= want_mm || want_smm;
      spec_data_en                   <= is_spec && osc_ready && lo_locked && ifp_ready && smm_rx_en;
    end
  end

  // ==========================================================================
  // Timers
  logic               tick;
  logic               cycle_wrap;
  logic               lo_wrap;
  logic               set_wrap;
  logic               seq_restart;
  logic [TIMER_W-1:0] phase_sec;

  mcs_tick_gen #(
    .CYCLES (SEC_CYCLES)
  ) u_tick (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .tick    (tick)
  );

  // Whole observation cycle
  mcs_period_counter u_cycle (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .restart (seq_restart),
    .tick    (tick),
    .length  (TIMER_W'(CYCLE_S)),
    .wrap    (cycle_wrap),
    .count   ()
  );

  // Offset switching period
  mcs_period_counter u_lo (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .restart (seq_restart),
    .tick    (tick),
    .length  (TIMER_W'(LO_SWITCH_S)),
    .wrap    (lo_wrap),
    .count   ()
  );

  // Continuum set period
  mcs_period_counter u_set (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .restart (seq_restart),
    .tick    (tick),
    .length  (TIMER_W'(CONT_SET_S)),
    .wrap    (set_wrap),
    .count   ()
  );

  // A new mode or the end of a cycle starts the sequence from the hot load, or from idle in engineering mode
  assign seq_restart = cmd_accept || cycle_wrap;

  // ==========================================================================
  // Observation sequence
  logic phase_end;
  assign phase_end = tick && (phase_sec == TIMER_W'(CAL_PHASE_S - 1));

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      seq_state <= MCS_SEQ_IDLE;
      phase_sec <= '0;
    end else if (seq_restart) begin
      seq_state <= (power_mode == MODE_ENG) ? MCS_SEQ_IDLE : MCS_SEQ_HOT;
      phase_sec <= '0;
    end else begin
      if (tick) begin
        phase_sec <= phase_end ? '0 : phase_sec + TIMER_W'(1);
      end
      case (seq_state)
        MCS_SEQ_IDLE: seq_state <= MCS_SEQ_IDLE;
        MCS_SEQ_HOT:  seq_state <= phase_end ? MCS_SEQ_COLD : MCS_SEQ_HOT;
        MCS_SEQ_COLD: seq_state <= phase_end ? MCS_SEQ_CAL : MCS_SEQ_COLD;
        MCS_SEQ_CAL:  seq_state <= phase_end ? MCS_SEQ_SRC : MCS_SEQ_CAL;
        MCS_SEQ_SRC:  seq_state <= MCS_SEQ_SRC;
        default:      seq_state <= MCS_SEQ_IDLE;
      endcase
    end
  end

  // Local oscillator offset
  // Both settings low outside spectroscopic modes so the LO sits on centre;
  // a restart out of idle must still load the minus setting
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      plus_offset_setting  <= 1'b0;
      minus_offset_setting <= 1'b0;
    end else if (!is_spec || ((seq_state == MCS_SEQ_IDLE) && !seq_restart)) begin
      plus_offset_setting  <= 1'b0;
      minus_offset_setting <= 1'b0;
    end else if (seq_restart) begin
      plus_offset_setting  <= 1'b0;
      minus_offset_setting <= 1'b1;
    end else if (lo_wrap) begin
      plus_offset_setting  <= ~plus_offset_setting;
      minus_offset_setting <= plus_offset_setting;
    end
  end

  // ==========================================================================
  // Spectroscopic data sets
  logic [2:0] spec_sets_done;
  logic [2:0] avg_target;
  assign avg_target = 3'({1'b0, integ_code} + 3'h1);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      spec_cal_dump  <= 1'b0;
      spec_sig_dump  <= 1'b0;
      spec_sig_diff  <= 1'b0;
      spec_avg_sets  <= 3'h1;
      spec_sets_done <= 3'h0;
    end else begin
      spec_avg_sets <= avg_target;
      spec_sig_diff <= is_spec && ((seq_state == MCS_SEQ_CAL) || (seq_state == MCS_SEQ_SRC));
      // Hot and cold phases each give one 15 s sum per offset
      spec_cal_dump <= is_spec && phase_end && !seq_restart &&
                       ((seq_state == MCS_SEQ_HOT) || (seq_state == MCS_SEQ_COLD));
      // Source sets accumulate until the integration count is reached
      if (seq_restart) begin
        spec_sets_done <= 3'h0;
        spec_sig_dump  <= 1'b0;
      end else if (is_spec && phase_end && (seq_state == MCS_SEQ_CAL)) begin
        spec_sets_done <= 3'h0;
        spec_sig_dump  <= 1'b1;
      end else if (is_spec && phase_end && (seq_state == MCS_SEQ_SRC)) begin
        spec_sets_done <= (spec_sets_done + 3'h1 == avg_target) ? 3'h0 : spec_sets_done + 3'h1;
        spec_sig_dump  <= (spec_sets_done + 3'h1 == avg_target);
      end else begin
        spec_sig_dump  <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Continuum summing
  // Sets are added, never divided, so the output stays in raw counts
  logic [4:0] sum_target;
  logic [4:0] cont_sets_done;

  always_comb begin
    case (sum_code)
      3'h0:    sum_target = 5'h01;
      3'h1:    sum_target = 5'h02;
      3'h2:    sum_target = 5'h05;
      3'h3:    sum_target = 5'h0a;
      3'h4:    sum_target = 5'h14;
      default: sum_target = 5'h01;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cont_dump      <= 1'b0;
      cont_sum_sets  <= 5'h01;
      cont_sets_done <= 5'h00;
    end else begin
      cont_sum_sets <= sum_target;
      if (seq_restart || (power_mode == MODE_ENG)) begin
        cont_sets_done <= 5'h00;
        cont_dump      <= 1'b0;
      end else if (set_wrap) begin
        cont_sets_done <= (cont_sets_done + 5'h01 == sum_target) ? 5'h00 : cont_sets_done + 5'h01;
        cont_dump      <= (cont_sets_done + 5'h01 == sum_target);
      end else begin
        cont_dump      <= 1'b0;
      end
    end
  end

endmodule

// ==== test/mcs_monitor.sv ====
// Port checker for the mode-change sequencer.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/100ps
module mcs_monitor
  import mcs_pkg::*;
(
  // Clock, reset, command path
  input wire logic              clk_sys,
  input wire logic              reset_n,
  input wire logic              tc_valid,
  input wire logic              cmd_accept,
  input wire logic              cmd_reject,
  // Settings
  input wire logic [2:0]        power_mode,
  input wire logic [1:0]        integ_code,
  input wire logic [2:0]        spec_avg_sets,
  // Enables and sequence
  input wire logic              flight_computer_en,
  input wire logic              mm_rx_en,
  input wire logic              smm_rx_en,
  input wire logic              spectro_en,
  input wire logic              eng_tm_en,
  input wire mcs_pkg::mcs_seq_t seq_state,
  input wire logic              plus_offset_setting,
  input wire logic              minus_offset_setting
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ==========
  // Enables follow a settled mode
  mode_code_a: assert property (power_mode inside {[MODE_SPEC_DUAL:MODE_ENG]})
    else $error("power mode code out of range");
  flight_on_a: assert property (flight_computer_en)
    else $error("flight computer unpowered");
  eng_only_a: assert property (power_mode == MODE_ENG && $stable(power_mode) |-> eng_tm_en && !mm_rx_en && !smm_rx_en && !spectro_en)
    else $error("engineering mode powers extra units");
  mm_only_a: assert property (power_mode == MODE_MM && $stable(power_mode) |-> mm_rx_en && !smm_rx_en && !spectro_en)
    else $error("millimetre mode enables wrong");
  // Mode moves only on an accepted command, answer tied to a byte
  mode_hold_a: assert property ($changed(power_mode) |-> cmd_accept)
    else $error("mode changed without accept");
  answer_cause_a: assert property (cmd_accept || cmd_reject |-> $past(tc_valid))
    else $error("answer without a final byte");
  hot_start_a: assert property (cmd_accept && power_mode != MODE_ENG |=> seq_state == MCS_SEQ_HOT)
    else $error("sequence did not restart on hot load");
  offset_excl_a: assert property (!(plus_offset_setting && minus_offset_setting))
    else $error("both offsets active");
  offset_swap_a: assert property ($rose(plus_offset_setting) |-> $fell(minus_offset_setting))
    else $error("offset switched without swap");
  avg_sets_a: assert property ($stable(integ_code) |-> spec_avg_sets == {1'b0, integ_code} + 3'h1)
    else $error("averaged set count wrong");
  cover property (cmd_accept && power_mode == MODE_SPEC_SMM);
  cover property (cmd_reject);
  cover property ($rose(plus_offset_setting));
endmodule

bind mcs_sequencer mcs_monitor i_mon (.clk_sys(clk_sys), .reset_n(reset_n), .tc_valid(tc_valid),
  .cmd_accept(cmd_accept), .cmd_reject(cmd_reject), .power_mode(power_mode), .integ_code(integ_code),
  .spec_avg_sets(spec_avg_sets), .flight_computer_en(flight_computer_en), .mm_rx_en(mm_rx_en),
  .smm_rx_en(smm_rx_en), .spectro_en(spectro_en), .eng_tm_en(eng_tm_en), .seq_state(seq_state),
  .plus_offset_setting(plus_offset_setting), .minus_offset_setting(minus_offset_setting));

// ==== test/mcs_tc_source.sv ====
// Telecommand source model sending mode-change packets byte by byte.
// Assumes send is called just after a rising edge of clk_sys.
`timescale 1ns/100ps
module mcs_tc_source (
  // Clock
  input  wire logic       clk_sys,
  // Byte stream
  output logic            tc_valid,
  output logic            tc_first,
  output wire logic [7:0] tc_byte
);
  import mcs_pkg::*;
  logic [10:0] cnt;
  logic [7:0]  dat;
  logic [7:0]  noise = 8'h5a;
  // Idle bus shows changing junk, never a held byte
  assign tc_byte = tc_valid ? dat : noise;
  initial begin
    tc_valid = 1'b0;
    tc_first = 1'b0;
    cnt = 11'h000; // single source combination
  end
  always @(posedge clk_sys) noise <= ~noise;
  // ==========
  // Packet sender with random stalls between bytes
  task automatic send(input logic [15:0] ad, input int bad, input logic [7:0] msk);
    logic [7:0] pk [14];
    pk = '{8'h1c, 8'h7c, {5'h18, cnt[10:8]}, cnt[7:0], 8'h00, 8'h07, 8'h11, SVC_TYPE, SVC_SUBTYPE, SVC_PAD,
           ad[15:8], ad[7:0], 8'($urandom), 8'($urandom)};
    if (bad < 14) pk[bad] ^= msk;
    for (int i = 0; i < 14; i++) begin
      while ($urandom_range(3) == 0) begin
        tc_valid <= 1'b0;
        @(posedge clk_sys);
      end
      tc_valid <= 1'b1;
      tc_first <= (i == 0);
      dat <= pk[i];
      @(posedge clk_sys);
    end
    tc_valid <= 1'b0;
    cnt <= cnt + 11'h001;
  endtask
endmodule

// ==== test/tb_top.sv ====
// Self-checking bench for the mode-change sequencer.
// Assumes a 10-cycle tick, so each calibration phase lasts 300 clocks.
`timescale 1ns/100ps
module tb_top;
  import mcs_pkg::*;
  logic        clk_sys, reset_n, osc_ready, lo_locked, ifp_ready, tc_valid, tc_first, cmd_accept, cmd_reject;
  logic        flight_computer_en, mm_rx_en, smm_rx_en, stable_reference_oscillator_en, spectro_en;
  logic        eng_tm_en, spec_data_en, plus_offset_setting, minus_offset_setting;
  wire  [7:0]  tc_byte;
  logic [10:0] last_tc_count;
  logic [2:0]  power_mode, sum_code, spec_avg_sets, em, esm;
  logic [1:0]  integ_code, eig;
  logic [4:0]  cont_sum_sets;
  mcs_seq_t    seq_state;
  int          errors, samples_checked, npk, lt;
  mcs_tc_source i_src (.clk_sys(clk_sys), .tc_valid(tc_valid), .tc_first(tc_first), .tc_byte(tc_byte));
  mcs_sequencer #(.SEC_CYCLES(10)) i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .tc_valid(tc_valid),
    .tc_first(tc_first), .tc_byte(tc_byte), .osc_ready(osc_ready), .lo_locked(lo_locked), .ifp_ready(ifp_ready),
    .cmd_accept(cmd_accept), .cmd_reject(cmd_reject), .last_tc_count(last_tc_count), .power_mode(power_mode),
    .integ_code(integ_code), .sum_code(sum_code), .smooth_code(), .flight_computer_en(flight_computer_en),
    .mm_rx_en(mm_rx_en), .smm_rx_en(smm_rx_en), .stable_reference_oscillator_en(stable_reference_oscillator_en),
    .spectro_en(spectro_en), .eng_tm_en(eng_tm_en), .cont_data_en(), .spec_data_en(spec_data_en),
    .seq_state(seq_state), .plus_offset_setting(plus_offset_setting), .minus_offset_setting(minus_offset_setting),
    .spec_cal_dump(), .spec_sig_dump(), .spec_sig_diff(), .spec_avg_sets(spec_avg_sets), .cont_dump(),
    .cont_sum_sets(cont_sum_sets));
  // ==========
  // Expectations: mm, smm, spectrometer, oscillator, eng telemetry
  function automatic logic [4:0] en_of(input logic [2:0] m);
    case (m)
      MODE_MM:        return 5'h10;
      MODE_SMM:       return 5'h08;
      MODE_DUAL:      return 5'h18;
      MODE_SPEC_SMM:  return 5'h0e;
      MODE_SPEC_DUAL: return 5'h1e;
      default:        return 5'h01;
    endcase
  endfunction
  function automatic logic [4:0] sets_of(input logic [2:0] s);
    case (s)
      3'h0:    return 5'h01;
      3'h1:    return 5'h02;
      3'h2:    return 5'h05;
      3'h3:    return 5'h0a;
      default: return 5'h14;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Sample a little after the edge so updates have landed
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic go(input logic [2:0] m, input logic [1:0] ig, input logic [2:0] sm, input int bad,
                    input logic [7:0] msk);
    logic acc;
    acc = bad > 13 && m inside {[1:6]} && sm < 3'h5;
    @(posedge clk_sys);
    i_src.send({m, ig, sm, 2'($urandom), 6'h00}, bad, msk);
    #1;
    for (int w = 0; w < 4 && cmd_accept !== 1'b1 && cmd_reject !== 1'b1; w++) wt(1);
    chk("cmd_accept", 16'(acc), 16'(cmd_accept));
    if (acc) begin
      em = m;
      eig = ig;
      esm = sm;
      lt = npk;
    end
    npk++;
    wt(2);
    chk("power_mode", 16'(em), 16'(power_mode));
    chk("enables", 16'(en_of(em)), 16'({mm_rx_en, smm_rx_en, spectro_en, stable_reference_oscillator_en,
      eng_tm_en}));
    chk("spec_avg_sets", 16'(eig) + 16'h1, 16'(spec_avg_sets));
    chk("cont_sum_sets", 16'(sets_of(esm)), 16'(cont_sum_sets));
    chk("last_tc_count", 16'(lt), 16'(last_tc_count));
  endtask
  task automatic summarize();
    $display("Checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Watchdog: run needs about 21000 clocks
  initial begin
    #400000;
    errors++;
    summarize();
  end
  initial begin
    errors = 0;
    samples_checked = 0;
    npk = 0;
    lt = 0;
    em = MODE_ENG;
    eig = 2'h0;
    esm = 3'h0;
    reset_n = 1'b0;
    {osc_ready, lo_locked, ifp_ready} = 3'h7;
    void'($urandom(30807));
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    wt(1);
    chk("power_mode", 16'(MODE_ENG), 16'(power_mode));
    for (int k = 1; k < 7; k++) go(3'(k), 2'($urandom), 3'($urandom_range(4)), 99, 8'h00);
    // One fixed field broken per packet, then illegal codes
    for (int b = 0; b < 10; b++) if (b != 3) go(3'h3, 2'h1, 3'h2, b, b == 2 ? 8'h20 : 8'h80);
    go(3'h0, 2'h0, 3'h0, 99, 8'h00);
    go(3'h7, 2'h0, 3'h0, 99, 8'h00);
    go(MODE_MM, 2'h0, 3'h5, 99, 8'h00);
    // Spectroscopic phases and offset switching
    go(MODE_SPEC_SMM, 2'h3, 3'h1, 99, 8'h00);
    wt(20);
    chk("minus_offset_setting", 16'h1, 16'(minus_offset_setting));
    wt(50);
    chk("plus_offset_setting", 16'h1, 16'(plus_offset_setting));
    wt(78);
    chk("hot", 16'(MCS_SEQ_HOT), 16'(seq_state));
    wt(300);
    chk("cold", 16'(MCS_SEQ_COLD), 16'(seq_state));
    wt(300);
    chk("cal", 16'(MCS_SEQ_CAL), 16'(seq_state));
    wt(300);
    chk("src", 16'(MCS_SEQ_SRC), 16'(seq_state));
    @(posedge clk_sys) {osc_ready, lo_locked, ifp_ready} <= ~(3'h1 << $urandom_range(2));
    wt(4);
    chk("spec_data_en", 16'h0, 16'(spec_data_en));
    @(posedge clk_sys) {osc_ready, lo_locked, ifp_ready} <= 3'h7;
    wt(4);
    chk("spec_data_en", 16'h1, 16'(spec_data_en));
    wt(19370);
    chk("restart", 16'(MCS_SEQ_HOT), 16'(seq_state));
    summarize();
  end
endmodule
